// ===== rtl/bit_cells_defs.svh
// Register map, reset values and retention masks for the bit-cell bank.
// Assumes one register word of eight bits per address.
`ifndef BIT_CELLS_DEFS_SVH
`define BIT_CELLS_DEFS_SVH

`define CELL_WIDTH 8
`define CELL_ADDR_WIDTH 4
`define CELL_REG_COUNT 12

// Register index, equal to its address
`define IDX_READ_ONLY 0
`define IDX_SET_ON_READ 1
`define IDX_CLEAR_ON_READ 2
`define IDX_WRITE_ONLY 3
`define IDX_WRITE_ONE_CLEAR 4
`define IDX_WRITE_ANY_CLEAR 5
`define IDX_LATCH_LOW 6
`define IDX_LATCH_HIGH 7
`define IDX_SELF_CLEARING 8
`define IDX_SELF_SETTING 9
`define IDX_STICKY_HIGH 10
`define IDX_LEVEL_STICKY 11

// Reset values, register 11 in the top byte
`define CELL_RESET_VALUES 96'h00_00_ff_00_00_ff_00_00_00_00_00_00

// Bits kept through a lite reset
`define LITE_IMMUNE_MASKS 96'h00_00_ff_00_00_00_00_00_ff_00_00_00

// Bits kept through a software reset
`define SOFT_IMMUNE_MASKS 96'h00_00_0f_00_00_00_00_00_ff_00_00_00

`endif

// ===== rtl/bit_cells_pkg.sv
// Types shared by the bit-cell bank.
// Assumes bit_cells_defs.svh is included before use.
`include "bit_cells_defs.svh"

package bit_cells_pkg;
  typedef logic [`CELL_WIDTH-1:0] word_type;
  typedef logic [`CELL_ADDR_WIDTH-1:0] addr_type;
  typedef logic [`CELL_REG_COUNT-1:0] select_type;
endpackage

// ===== rtl/access_decode.sv
// Address decode of host read and write strobes into per-register selects.
// Assumes strobes are single-cycle pulses of completed accesses.
`timescale 1ns/1ns
`default_nettype none
`include "bit_cells_defs.svh"

module access_decode (
  // Host access
  input wire logic i_rd_stb,
  input wire logic i_wr_stb,
  input wire bit_cells_pkg::addr_type i_addr,
  // Selects
  output bit_cells_pkg::select_type o_rd_sel,
  output bit_cells_pkg::select_type o_wr_sel
);

  function automatic bit_cells_pkg::select_type one_hot(input logic en, input bit_cells_pkg::addr_type addr);
    bit_cells_pkg::select_type sel;
    sel = '0;
    for (int i = 0; i < `CELL_REG_COUNT; i++) begin
      if (en && (addr == i[`CELL_ADDR_WIDTH-1:0])) begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction

  always_comb begin
    o_rd_sel = one_hot(i_rd_stb, i_addr);
    o_wr_sel = one_hot(i_wr_stb, i_addr);
  end

endmodule
`default_nettype wire

// ===== rtl/reset_merge.sv
// Applies lite and software resets to one register's next value.
// Assumes both resets are synchronous, active-high levels.
`timescale 1ns/1ns
`default_nettype none

module reset_merge #(
  parameter bit_cells_pkg::word_type RESET_VALUE = '0,
  parameter bit_cells_pkg::word_type LITE_KEEP = '0,
  parameter bit_cells_pkg::word_type SOFT_KEEP = '0
) (
  // Resets
  input wire logic i_lite_rst,
  input wire logic i_soft_rst,
  // Values
  input wire bit_cells_pkg::word_type i_value,
  output bit_cells_pkg::word_type o_value
);

  always_comb begin
    o_value = i_value;
    if (i_lite_rst) begin
      o_value = (o_value & LITE_KEEP) | (RESET_VALUE & ~LITE_KEEP);
    end
    if (i_soft_rst) begin
      o_value = (o_value & SOFT_KEEP) | (RESET_VALUE & ~SOFT_KEEP);
    end
  end

endmodule
`default_nettype wire

// ===== rtl/register_bit_access_cells.sv
// Bank of twelve eight-bit registers, one per bit-access behaviour.
// Assumes a host port giving single-cycle read and write strobes of completed
// accesses, and hardware condition and event inputs synchronous to I_CLOCK.
//
// Behaviour
// - Read-only bits ignore every write
// - Set-on-read bits become one when read
// - Clear-on-read returns value, then clears; writes ignored
// - Write-only bits accepted; read-back content unspecified
// - Writing one clears; writing zero keeps
// - Any write clears write-anything-to-clear bits
// - Latch low/high held until register read
// - Self-clearing bit returns zero when action completes
// - Self-setting bit returns to one on its own
// - Latch-high-until-read then follows its condition
// - Lite-reset immune bits keep their value
// - Software-reset immune bits keep their value
// - Reserved bits written zero; read value unguaranteed
// - Level sticky clears on zero write, condition gone
`timescale 1ns/1ns
`default_nettype none
`include "bit_cells_defs.svh"

module register_bit_access_cells (
  // Clock and resets
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_LITE_RST,
  input wire logic I_SOFT_RST,
  // Host access port
  input wire logic I_RD_STB,
  input wire logic I_WR_STB,
  input wire bit_cells_pkg::addr_type I_ADDR,
  input wire bit_cells_pkg::word_type I_WDATA,
  output bit_cells_pkg::word_type O_RDATA,
  output logic O_RD_VALID,
  // Hardware conditions and events
  input wire bit_cells_pkg::word_type I_STATUS,
  input wire bit_cells_pkg::word_type I_RS_CLEAR,
  input wire bit_cells_pkg::word_type I_RC_EVENT,
  input wire bit_cells_pkg::word_type I_W1C_EVENT,
  input wire bit_cells_pkg::word_type I_WAC_EVENT,
  input wire bit_cells_pkg::word_type I_LOW_COND,
  input wire bit_cells_pkg::word_type I_HIGH_COND,
  input wire bit_cells_pkg::word_type I_SC_DONE,
  input wire bit_cells_pkg::word_type I_SS_DONE,
  input wire bit_cells_pkg::word_type I_STICKY_COND,
  input wire bit_cells_pkg::word_type I_LEVEL_COND,
  // Control outputs
  output bit_cells_pkg::word_type O_WO_CTRL,
  output bit_cells_pkg::word_type O_SC_ACTION,
  output bit_cells_pkg::word_type O_SS_VALUE
);

  localparam logic [`CELL_REG_COUNT*`CELL_WIDTH-1:0] reset_values = `CELL_RESET_VALUES;
  localparam logic [`CELL_REG_COUNT*`CELL_WIDTH-1:0] lite_masks = `LITE_IMMUNE_MASKS;
  localparam logic [`CELL_REG_COUNT*`CELL_WIDTH-1:0] soft_masks = `SOFT_IMMUNE_MASKS;

  bit_cells_pkg::select_type rd_sel;
  bit_cells_pkg::select_type wr_sel;
  bit_cells_pkg::word_type val_reg [`CELL_REG_COUNT];
  bit_cells_pkg::word_type val_raw [`CELL_REG_COUNT];
  bit_cells_pkg::word_type val_next [`CELL_REG_COUNT];
  bit_cells_pkg::word_type high_prev_reg;
  bit_cells_pkg::word_type high_prev_next;
  bit_cells_pkg::word_type low_prev_reg;
  bit_cells_pkg::word_type low_prev_next;
  bit_cells_pkg::word_type rdata_reg;
  bit_cells_pkg::word_type rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;

  access_decode u_decode (
    .i_rd_stb(I_RD_STB),
    .i_wr_stb(I_WR_STB),
    .i_addr(I_ADDR),
    .o_rd_sel(rd_sel),
    .o_wr_sel(wr_sel)
  );

  // Value seen by a read; write-only and unmapped read as zero
  function automatic bit_cells_pkg::word_type read_value(input bit_cells_pkg::addr_type addr,
                                                         input bit_cells_pkg::word_type cur);
    bit_cells_pkg::word_type v;
    v = cur;
    if (addr == `CELL_ADDR_WIDTH'(`IDX_WRITE_ONLY)) begin
      v = '0;
    end
    if (addr >= `CELL_ADDR_WIDTH'(`CELL_REG_COUNT)) begin
      v = '0;
    end
    return v;
  endfunction

  // Cell behaviour before lite and software resets
  always_comb begin
    for (int i = 0; i < `CELL_REG_COUNT; i++) begin
      val_raw[i] = val_reg[i];
    end

    val_raw[`IDX_READ_ONLY] = I_STATUS;

    // read sets every bit
    // Read wins over hardware clear so a read is never lost
    val_raw[`IDX_SET_ON_READ] = val_reg[`IDX_SET_ON_READ] & ~I_RS_CLEAR;
    if (rd_sel[`IDX_SET_ON_READ]) begin
      val_raw[`IDX_SET_ON_READ] = '1;
    end

    if (rd_sel[`IDX_CLEAR_ON_READ]) begin
      val_raw[`IDX_CLEAR_ON_READ] = '0;
    end
    val_raw[`IDX_CLEAR_ON_READ] = val_raw[`IDX_CLEAR_ON_READ] | I_RC_EVENT;

    if (wr_sel[`IDX_WRITE_ONLY]) begin
      val_raw[`IDX_WRITE_ONLY] = I_WDATA;
    end

    if (wr_sel[`IDX_WRITE_ONE_CLEAR]) begin
      val_raw[`IDX_WRITE_ONE_CLEAR] = val_reg[`IDX_WRITE_ONE_CLEAR] & ~I_WDATA;
    end
    val_raw[`IDX_WRITE_ONE_CLEAR] = val_raw[`IDX_WRITE_ONE_CLEAR] | I_W1C_EVENT;

    if (wr_sel[`IDX_WRITE_ANY_CLEAR]) begin
      val_raw[`IDX_WRITE_ANY_CLEAR] = '0;
    end
    val_raw[`IDX_WRITE_ANY_CLEAR] = val_raw[`IDX_WRITE_ANY_CLEAR] | I_WAC_EVENT;

    // latch low released by read
    // A falling condition wins over the release in the same cycle
    if (rd_sel[`IDX_LATCH_LOW]) begin
      val_raw[`IDX_LATCH_LOW] = '1;
    end
    val_raw[`IDX_LATCH_LOW] = val_raw[`IDX_LATCH_LOW] & ~(low_prev_reg & ~I_LOW_COND);

    if (rd_sel[`IDX_LATCH_HIGH]) begin
      val_raw[`IDX_LATCH_HIGH] = '0;
    end
    val_raw[`IDX_LATCH_HIGH] = val_raw[`IDX_LATCH_HIGH] | (I_HIGH_COND & ~high_prev_reg);

    // software sets, done clears
    // Zero writes do nothing; a fresh start beats a completion
    val_raw[`IDX_SELF_CLEARING] = val_reg[`IDX_SELF_CLEARING] & ~I_SC_DONE;
    if (wr_sel[`IDX_SELF_CLEARING]) begin
      val_raw[`IDX_SELF_CLEARING] = val_raw[`IDX_SELF_CLEARING] | I_WDATA;
    end

    // software clears, done sets
    // Hardware return to one wins over a clearing write
    if (wr_sel[`IDX_SELF_SETTING]) begin
      val_raw[`IDX_SELF_SETTING] = val_reg[`IDX_SELF_SETTING] & I_WDATA;
    end
    val_raw[`IDX_SELF_SETTING] = val_raw[`IDX_SELF_SETTING] | I_SS_DONE;

    if (rd_sel[`IDX_STICKY_HIGH]) begin
      val_raw[`IDX_STICKY_HIGH] = '0;
    end
    val_raw[`IDX_STICKY_HIGH] = val_raw[`IDX_STICKY_HIGH] | I_STICKY_COND;

    if (wr_sel[`IDX_LEVEL_STICKY]) begin
      val_raw[`IDX_LEVEL_STICKY] = val_reg[`IDX_LEVEL_STICKY] & I_WDATA;
    end
    val_raw[`IDX_LEVEL_STICKY] = val_raw[`IDX_LEVEL_STICKY] | I_LEVEL_COND;
  end

  // lite and soft resets per register
  for (genvar g = 0; g < `CELL_REG_COUNT; g++) begin : g_merge
    reset_merge #(
      .RESET_VALUE(reset_values[g*`CELL_WIDTH +: `CELL_WIDTH]),
      .LITE_KEEP(lite_masks[g*`CELL_WIDTH +: `CELL_WIDTH]),
      .SOFT_KEEP(soft_masks[g*`CELL_WIDTH +: `CELL_WIDTH])
    ) u_merge (
      .i_lite_rst(I_LITE_RST),
      .i_soft_rst(I_SOFT_RST),
      .i_value(val_raw[g]),
      .o_value(val_next[g])
    );
  end

  always_ff @(posedge I_CLOCK) begin
    for (int i = 0; i < `CELL_REG_COUNT; i++) begin
      if (!I_RST_B) begin
        val_reg[i] <= reset_values[i*`CELL_WIDTH +: `CELL_WIDTH];
      end else begin
        val_reg[i] <= val_next[i];
      end
    end
  end

  // Edge history for the latch cells
  always_comb begin
    high_prev_next = I_HIGH_COND;
    low_prev_next = I_LOW_COND;
  end

  // Reset history to idle levels so no false edge after reset
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      high_prev_reg <= '0;
      low_prev_reg <= '1;
    end else begin
      high_prev_reg <= high_prev_next;
      low_prev_reg <= low_prev_next;
    end
  end

  // value captured before clearing
  // Read data holds until the next read
  always_comb begin
    rdata_next = rdata_reg;
    rd_valid_next = 1'b0;
    if (I_RD_STB) begin
      rd_valid_next = 1'b1;
      if (I_ADDR < `CELL_ADDR_WIDTH'(`CELL_REG_COUNT)) begin
        rdata_next = read_value(I_ADDR, val_reg[I_ADDR]);
      end else begin
        rdata_next = read_value(I_ADDR, '0);
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      rdata_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  always_comb begin
    O_RDATA = rdata_reg;
    O_RD_VALID = rd_valid_reg;
    O_WO_CTRL = val_reg[`IDX_WRITE_ONLY];
    O_SC_ACTION = val_reg[`IDX_SELF_CLEARING];
    O_SS_VALUE = val_reg[`IDX_SELF_SETTING];
  end

endmodule
`default_nettype wire

// ===== testbench/bit_cells_checker.sv
// Port checker for the bit-cell bank.
// Assumes it is bound to register_bit_access_cells.
`timescale 1ns/1ns
`default_nettype none
module bit_cells_checker (
  // Clock and resets
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_LITE_RST,
  input wire logic I_SOFT_RST,
  // Host access
  input wire logic I_RD_STB,
  input wire logic I_WR_STB,
  input wire bit_cells_pkg::addr_type I_ADDR,
  input wire bit_cells_pkg::word_type I_WDATA,
  input wire logic O_RD_VALID,
  // Cells
  input wire bit_cells_pkg::word_type I_SC_DONE,
  input wire bit_cells_pkg::word_type I_SS_DONE,
  input wire bit_cells_pkg::word_type O_WO_CTRL,
  input wire bit_cells_pkg::word_type O_SC_ACTION,
  input wire bit_cells_pkg::word_type O_SS_VALUE
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  logic w8, w9, rr;
  assign w8 = I_WR_STB && I_ADDR == 4'h8;
  assign w9 = I_WR_STB && I_ADDR == 4'h9;
  // Lite and soft resets both reload self-clearing bits
  assign rr = I_LITE_RST || I_SOFT_RST;
  a_valid_after_read: assert property (O_RD_VALID == $past(I_RD_STB))
    else $error("read valid not one cycle after read");
  a_wo_loads: assert property (I_WR_STB && I_ADDR == 4'h3 |=> O_WO_CTRL == $past(I_WDATA))
    else $error("write-only word not loaded");
  a_wo_keeps: assert property (!(I_WR_STB && I_ADDR == 4'h3) |=> $stable(O_WO_CTRL))
    else $error("write-only word changed");
  a_sc_write: assert property (w8 && !rr |=> O_SC_ACTION == ($past(O_SC_ACTION) & ~$past(I_SC_DONE) | $past(I_WDATA)))
    else $error("self-clearing write wrong");
  a_sc_self_clear: assert property (!w8 && !rr |=> O_SC_ACTION == ($past(O_SC_ACTION) & ~$past(I_SC_DONE)))
    else $error("self-clearing bits wrong");
  a_ss_write: assert property (w9 && !I_SOFT_RST |=> O_SS_VALUE == ($past(O_SS_VALUE) & $past(I_WDATA) | $past(I_SS_DONE)))
    else $error("self-setting write wrong");
  a_ss_self_set: assert property (!w9 && !I_SOFT_RST |=> O_SS_VALUE == ($past(O_SS_VALUE) | $past(I_SS_DONE)))
    else $error("self-setting bits wrong");
  a_ss_soft_keep: assert property (I_SOFT_RST && !w9 |=> O_SS_VALUE == (8'hf0 | $past(O_SS_VALUE) | $past(I_SS_DONE)))
    else $error("soft reset on self-setting wrong");
endmodule
bind register_bit_access_cells bit_cells_checker u_checker (
  .I_CLOCK(I_CLOCK),
  .I_RST_B(I_RST_B),
  .I_LITE_RST(I_LITE_RST),
  .I_SOFT_RST(I_SOFT_RST),
  .I_RD_STB(I_RD_STB),
  .I_WR_STB(I_WR_STB),
  .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA),
  .O_RD_VALID(O_RD_VALID),
  .I_SC_DONE(I_SC_DONE),
  .I_SS_DONE(I_SS_DONE),
  .O_WO_CTRL(O_WO_CTRL),
  .O_SC_ACTION(O_SC_ACTION),
  .O_SS_VALUE(O_SS_VALUE)
);
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the bit-cell bank.
// Assumes the defines header and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  bit_cells_pkg::word_type st, rsc, rce, w1e, wae, lc, hc, scd, ssd, sk, lv, wd, rdat, wo, sca, ssv;
  bit_cells_pkg::addr_type ad;
  logic clk, rst_b, lr, sr, rs, ws, rv;
  int num_errors, checks;
  register_bit_access_cells u_dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_LITE_RST(lr), .I_SOFT_RST(sr),
    .I_RD_STB(rs), .I_WR_STB(ws), .I_ADDR(ad), .I_WDATA(wd), .O_RDATA(rdat), .O_RD_VALID(rv),
    .I_STATUS(st), .I_RS_CLEAR(rsc), .I_RC_EVENT(rce), .I_W1C_EVENT(w1e), .I_WAC_EVENT(wae),
    .I_LOW_COND(lc), .I_HIGH_COND(hc), .I_SC_DONE(scd), .I_SS_DONE(ssd), .I_STICKY_COND(sk),
    .I_LEVEL_COND(lv), .O_WO_CTRL(wo), .O_SC_ACTION(sca), .O_SS_VALUE(ssv));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task chk(input string n, input bit_cells_pkg::word_type e, input bit_cells_pkg::word_type g);
    checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task wr(input bit_cells_pkg::addr_type a, input bit_cells_pkg::word_type d);
    @(posedge clk);
    ws <= 1'h1;
    ad <= a;
    wd <= d;
    @(posedge clk);
    ws <= 1'h0;
    #1;
  endtask
  // Read data is the value before that edge's side effect
  task rd(input bit_cells_pkg::addr_type a, input bit_cells_pkg::word_type e);
    @(posedge clk);
    rs <= 1'h1;
    ad <= a;
    @(posedge clk);
    rs <= 1'h0;
    #1;
    chk("read data", e, rdat);
  endtask
  task s_rd;
    @(posedge clk) st <= 8'h3c;
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h3c); // status read, write ignored
    @(posedge clk) rce <= 8'h05;
    @(posedge clk) rce <= 8'h00;
    wr(4'h2, 8'h00);
    rd(4'hc, 8'h00); // no side effect
    rd(4'h2, 8'h05); // value kept
    rd(4'h2, 8'h00); // cleared
    // Event sampled only at the clearing read edge
    fork
      rd(4'h2, 8'h00);
      begin
        @(posedge clk) rce <= 8'h08;
        @(posedge clk) rce <= 8'h00;
      end
    join
    rd(4'h2, 8'h08); // event beats read clear
    rd(4'h1, 8'h00); // not set elsewhere
    rd(4'h1, 8'hff); // set by read
    @(posedge clk) rsc <= 8'h0f;
    @(posedge clk) rsc <= 8'h00;
    rd(4'h1, 8'hf0); // hardware clear
  endtask
  task s_wr;
    @(posedge clk) w1e <= 8'h0f;
    @(posedge clk) w1e <= 8'h00;
    wr(4'h4, 8'h03);
    rd(4'h4, 8'h0c); // ones clear
    // Event seen only at the clearing write edge, or the check proves nothing
    fork
      wr(4'h4, 8'h0c);
      begin
        @(posedge clk) w1e <= 8'h04;
        @(posedge clk) w1e <= 8'h00;
      end
    join
    rd(4'h4, 8'h04); // set wins
    @(posedge clk) wae <= 8'h81;
    @(posedge clk) wae <= 8'h00;
    rd(4'h5, 8'h81); // read keeps
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h00); // zero write clears
    // Condition present only at the zero-write edge
    fork
      wr(4'hb, 8'h00);
      begin
        @(posedge clk) lv <= 8'h02;
        @(posedge clk) lv <= 8'h00;
      end
    join
    rd(4'hb, 8'h02); // condition holds
    rd(4'hb, 8'h02); // still sticky
    wr(4'hb, 8'h00);
    rd(4'hb, 8'h00); // cleared
  endtask
  task s_latch;
    @(posedge clk) lc <= 8'hfe;
    @(posedge clk) lc <= 8'hff;
    @(posedge clk) hc <= 8'h80;
    @(posedge clk) hc <= 8'h00;
    @(posedge clk) sk <= 8'h01;
    @(posedge clk) sk <= 8'h00;
    rd(4'h6, 8'hfe); // low held
    rd(4'h6, 8'hff); // released
    rd(4'h7, 8'h80); // high held
    rd(4'h7, 8'h00); // released
    rd(4'ha, 8'h01); // held until read
    rd(4'ha, 8'h00); // drops
    @(posedge clk) sk <= 8'h02;
    rd(4'ha, 8'h02); // condition on
    rd(4'ha, 8'h02); // follows condition
  endtask
  task s_self;
    wr(4'h8, 8'h01);
    wr(4'h8, 8'h00);
    chk("sc action", 8'h01, sca); // zero write
    @(posedge clk) scd <= 8'h01;
    @(posedge clk) scd <= 8'h00;
    #1;
    chk("sc action", 8'h00, sca); // self cleared
    wr(4'h9, 8'hfe);
    wr(4'h9, 8'hff);
    chk("ss value", 8'hfe, ssv); // one write
    @(posedge clk) ssd <= 8'h01;
    @(posedge clk) ssd <= 8'h00;
    #1;
    chk("ss value", 8'hff, ssv); // self set
  endtask
  task s_rst;
    wr(4'h3, 8'ha5);
    wr(4'h9, 8'h00);
    @(posedge clk) w1e <= 8'h01;
    @(posedge clk) w1e <= 8'h00;
    @(posedge clk) lr <= 1'h1;
    @(posedge clk) lr <= 1'h0;
    #1;
    chk("ss value", 8'h00, ssv); // kept
    rd(4'h4, 8'h00); // reloaded
    @(posedge clk) sr <= 1'h1;
    @(posedge clk) sr <= 1'h0;
    #1;
    chk("wo ctrl", 8'ha5, wo); // kept
    chk("ss value", 8'hf0, ssv); // low half kept
  endtask
  task finish_test;
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {st, rsc, rce, w1e, wae, hc, scd, ssd, sk, lv, wd} = '0;
    lc = 8'hff;
    ad = 4'h0;
    {rst_b, lr, sr, rs, ws} = '0;
    num_errors = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    s_rd;
    s_wr;
    s_latch;
    s_self;
    s_rst;
    finish_test;
  end
endmodule
`default_nettype wire
